/* File: pkg/rsmt_pkg.sv */
`default_nettype none
package rsmt_pkg;
    // Master clock rate
    localparam int CLK_MHZ = 20;
    // Read raster times in ns, as printed
    localparam int H_ACT_NS      = 48900;
    localparam int H_RET_NS      = 12200;
    localparam int V_RET_ODD_NS  = 580500;
    localparam int V_RET_EVEN_NS = 611000;
    // Cycle counts derived from the times (whole cycles)
    localparam int H_ACT_CYC  = H_ACT_NS * CLK_MHZ / 1000;
    localparam int H_TOT_CYC  = (H_ACT_NS + H_RET_NS) * CLK_MHZ / 1000;
    localparam int V_ODD_CYC  = V_RET_ODD_NS * CLK_MHZ / 1000;
    localparam int V_EVEN_CYC = V_RET_EVEN_NS * CLK_MHZ / 1000;
    // Memory geometry
    localparam int LINES_FIELD = 256;
    localparam int N_COLS      = 10;
    localparam int N_ROWS      = 4;
    localparam int AZ_PER_COL  = 16;
    localparam int CELL_W      = 3;
    localparam int COL_DEPTH   = 2048;
    localparam int READ_SLOT   = H_ACT_CYC / AZ_PER_COL;
    localparam int QCLK_MAX    = 512;
    localparam int RANGE_LAST  = 511;
    // Field widths
    localparam int ALT_W = 10;
    localparam int CREG_W = 9;
    localparam int SIN_W = 9;
    localparam int TAP_W = 3;
    // APB register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ALT    = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_COUNT  = 8'h0C;
    // Control field positions and reset values
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_TAP_LSB  = 2;
    localparam int CTRL_WEN_BIT  = 5;
    localparam logic [5:0] CTRL_RST = 6'h20;
    localparam logic [ALT_W-1:0] ALT_RST = 10'h000;
    // Display/range modes
    typedef enum logic [1:0] {
        RSMT_SLANT  = 2'b00,
        RSMT_GROUND = 2'b01,
        RSMT_EXP    = 2'b10
    } rsmt_mode_t;
    // Vertical raster state
    typedef enum logic {
        RSMT_V_ACT = 1'b0,
        RSMT_V_RET = 1'b1
    } rsmt_vst_t;
    // Unload sequencer state
    typedef enum logic [1:0] {
        RSMT_UL_IDLE = 2'b00,
        RSMT_UL_LOAD = 2'b01,
        RSMT_UL_RUN  = 2'b10
    } rsmt_ul_t;
endpackage
`default_nettype wire

/* File: design/rsmt_top.sv */
// The implementer's own choices: the APB slave port and the placing of the registers.
`default_nettype none
module rsmt_top
    import rsmt_pkg::*;
#(
    parameter int VRET_ODD_CYC  = V_ODD_CYC,
    parameter int VRET_EVEN_CYC = V_EVEN_CYC
)(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        radarMasterTrigger,
    input  wire logic [7:0]  antennaAz,
    input  wire logic [2:0]  integData,
    output logic             quantClk,
    output logic             integShift,
    output logic             compositeSync,
    output logic      [29:0] videoWord,
    output logic             bufferLoad,
    output logic             unloadBusy
);

    // Larger of two cell samples
    function automatic logic [2:0] max3(input logic [2:0] a,
                                        input logic [2:0] b);
        max3 = (a > b) ? a : b;
    endfunction

    // Address inside one column module
    function automatic logic [10:0] colAddr(input logic [6:0] grp,
                                            input logic [3:0] azLo);
        colAddr = {grp, azLo};
    endfunction

    logic              rstMeta_r;
    logic              rstSync_r;
    logic [5:0]        ctrl_r;
    logic [ALT_W-1:0]  alt_r;
    logic              pready_r;
    logic              pslverr_r;
    logic [31:0]       prdata_r;
    logic [10:0]       hCnt_r;
    logic [5:0]        slotPh_r;
    logic [4:0]        azSlot_r;
    logic [7:0]        lineCnt_r;
    logic              fieldOdd_r;
    logic [13:0]       vRetCnt_r;
    rsmt_vst_t         vState_r;
    logic              compSync_r;
    logic [29:0]       video_r;
    logic              bufLoad_r;
    logic [11:0]       memArr [N_COLS][COL_DEPTH];
    logic [7:0]        tmrCnt_r;
    logic              tapPrev_r;
    logic              qRun_r;
    logic [9:0]        qCount_r;
    logic              quantClk_r;
    logic [7:0]        azHold_r;
    logic [7:0]        ulAz_r;
    logic [7:0]        pendAz_r;
    logic              ulPend_r;
    rsmt_ul_t          ulState_r;
    logic [ALT_W-1:0]  cosCnt_r;
    logic [CREG_W-1:0] cosReg_r;
    logic [SIN_W-1:0]  sinCnt_r;
    logic [SIN_W-1:0]  sinReg_r;
    logic [8:0]        rangeAddr_r;
    logic [2:0]        curVal_r;
    logic [2:0]        peak_r;
    logic [8:0]        s2p_r;
    logic              integShift_r;
    logic              wrPend_r;
    logic [11:0]       wrData_r;
    logic [6:0]        wrGrp_r;
    logic [15:0]       unloadCnt_r;

    wire rstN = rstSync_r;

    // Reset release through two flops
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end
        else
        begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    // APB decode: one wait state, effect at the pready edge
    wire apbAcc    = psel & penable;
    wire apbDone   = apbAcc & pready_r;
    wire apbWr     = apbDone & pwrite;
    wire hitCtrl   = (paddr == REG_CTRL);
    wire hitAlt    = (paddr == REG_ALT);
    wire hitStatus = (paddr == REG_STATUS);
    wire hitCount  = (paddr == REG_COUNT);
    wire apbMapped = hitCtrl | hitAlt | hitStatus | hitCount;
    wire rsmt_mode_t mode = rsmt_mode_t'(ctrl_r[CTRL_MODE_LSB +: 2]);
    wire [TAP_W-1:0] tapSel = ctrl_r[CTRL_TAP_LSB +: TAP_W];
    wire wrSideEn  = ctrl_r[CTRL_WEN_BIT];
    wire [31:0] statusWord = {23'h000000, unloadCnt_r[1:0],
                              fieldOdd_r, vState_r, wrPend_r,
                              ulPend_r, unloadBusy, qRun_r,
                              1'b0};
    wire [31:0] countWord = {unloadCnt_r, 6'h00, qCount_r};
    wire [31:0] rdMux = hitCtrl   ? {26'h0000000, ctrl_r} :
                        hitAlt    ? {22'h000000, alt_r} :
                        hitStatus ? statusWord :
                        hitCount  ? countWord : 32'h00000000;

    // APB handshake and register writes
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
            ctrl_r    <= CTRL_RST;
            alt_r     <= ALT_RST;
        end
        else
        begin
            pready_r  <= apbAcc & ~pready_r;
            pslverr_r <= apbAcc & ~pready_r & ~apbMapped;
            if (apbAcc & ~pready_r)
                prdata_r <= rdMux;
            if (apbWr & hitCtrl)
                ctrl_r <= pwdata[5:0];
            if (apbWr & hitAlt)
                alt_r <= pwdata[ALT_W-1:0];
        end
    end

    // Read raster decode
    wire hActive  = hCnt_r < 11'(H_ACT_CYC);
    wire lineEnd  = hCnt_r == 11'(H_TOT_CYC - 1);
    wire vAct     = vState_r == RSMT_V_ACT;
    wire vRetEnd  = vRetCnt_r == (fieldOdd_r ? 14'(VRET_ODD_CYC - 1)
                                             : 14'(VRET_EVEN_CYC - 1));
    wire readStb  = vAct & hActive & (slotPh_r == 6'h00)
                    & (azSlot_r < 5'(AZ_PER_COL));
    wire [8:0] rdRange = {lineCnt_r, fieldOdd_r};
    wire [1:0] rdRow   = rdRange[1:0];
    wire [10:0] rdAddr = colAddr(rdRange[8:2], azSlot_r[3:0]);

    // Horizontal, slot and vertical counters
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            hCnt_r     <= 11'h000;
            slotPh_r   <= 6'h00;
            azSlot_r   <= 5'h00;
            lineCnt_r  <= 8'h00;
            fieldOdd_r <= 1'b0;
            vRetCnt_r  <= 14'h0000;
            vState_r   <= RSMT_V_ACT;
        end
        else
        begin
            hCnt_r <= lineEnd ? 11'h000 : hCnt_r + 11'h001;
            if (lineEnd | slotPh_r == 6'(READ_SLOT - 1))
                slotPh_r <= 6'h00;
            else
                slotPh_r <= slotPh_r + 6'h01;
            if (lineEnd)
                azSlot_r <= 5'h00;
            else if (readStb)
                azSlot_r <= azSlot_r + 5'h01;
            case (vState_r)
                RSMT_V_ACT:
                begin
                    if (lineEnd)
                    begin
                        lineCnt_r <= lineCnt_r + 8'h01;
                        if (lineCnt_r == 8'(LINES_FIELD - 1))
                        begin
                            vState_r  <= RSMT_V_RET;
                            vRetCnt_r <= 14'h0000;
                        end
                    end
                end
                RSMT_V_RET:
                begin
                    vRetCnt_r <= vRetCnt_r + 14'h0001;
                    if (vRetEnd)
                    begin
                        vState_r   <= RSMT_V_ACT;
                        fieldOdd_r <= ~fieldOdd_r;
                        lineCnt_r  <= 8'h00;
                        vRetCnt_r  <= 14'h0000;
                    end
                end
                default:
                    vState_r <= RSMT_V_ACT;
            endcase
        end
    end

    // Composite sync: line retrace or field retrace
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
            compSync_r <= 1'b0;
        else
            compSync_r <= (vAct & ~hActive) | ~vAct;
    end

    // Memory write: only in a cycle with no read
    wire wrGo = wrPend_r & ~readStb;
    wire [3:0] wrCol  = ulAz_r[7:4];
    wire [10:0] wrAddr = colAddr(wrGrp_r, ulAz_r[3:0]);

    // Column memories: write one column, read all columns
    always_ff @(posedge clk_sys)
    begin
        if (wrGo)
            memArr[wrCol][wrAddr] <= wrData_r;
        for (int c = 0; c < N_COLS; c++)
        begin
            if (readStb)
                video_r[c*CELL_W +: CELL_W] <=
                    memArr[c][rdAddr][rdRow*CELL_W +: CELL_W];
        end
    end

    // Output buffer load strobe
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
            bufLoad_r <= 1'b0;
        else
            bufLoad_r <= readStb;
    end

    // Quantizer clock from a selected tap of the trigger counter
    wire tapBit = tmrCnt_r[tapSel];
    wire qTick  = qRun_r & tapBit & ~tapPrev_r;
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            tmrCnt_r   <= 8'h00;
            tapPrev_r  <= 1'b0;
            qRun_r     <= 1'b0;
            qCount_r   <= 10'h000;
            quantClk_r <= 1'b0;
        end
        else
        begin
            // A restart swallows the tick of the old run
            quantClk_r <= qTick & ~(radarMasterTrigger & wrSideEn);
            if (radarMasterTrigger & wrSideEn)
            begin
                tmrCnt_r  <= 8'h00;
                tapPrev_r <= 1'b0;
                qRun_r    <= 1'b1;
                qCount_r  <= 10'h000;
            end
            else if (qRun_r)
            begin
                tmrCnt_r  <= tmrCnt_r + 8'h01;
                tapPrev_r <= tapBit;
                if (qTick)
                begin
                    qCount_r <= qCount_r + 10'h001;
                    if (qCount_r == 10'(QCLK_MAX - 1))
                        qRun_r <= 1'b0;
                end
            end
        end
    end

    // Unload step pacing from read timing, held off by writes
    wire stepTick = (hCnt_r[1:0] == 2'b00) & ~readStb;
    wire ulRun    = ulState_r == RSMT_UL_RUN;
    wire ulFree   = (ulState_r == RSMT_UL_IDLE) & ~wrPend_r;
    wire stepEn   = ulRun & stepTick & ~wrPend_r;
    wire azChange = antennaAz[0] != azHold_r[0];
    wire linear   = (mode == RSMT_SLANT) | (alt_r == ALT_RST);

    // Hyperbolic path arithmetic
    wire [CREG_W+1:0] cosSum = {2'b00, cosReg_r}
                               + {1'b0, cosCnt_r};
    wire [1:0] cosOvfN = cosSum[CREG_W+1:CREG_W];
    wire cosOvf = cosOvfN != 2'b00;
    wire dblOvf = cosOvfN == 2'b10;
    wire [SIN_W:0] sinSum = {1'b0, sinReg_r} + {1'b0, sinCnt_r};
    wire sinOvf = sinSum[SIN_W] & ~dblOvf;
    wire sinCntWrap = cosOvf & (sinCnt_r == {SIN_W{1'b1}});
    wire doShift = linear | sinOvf;
    wire doAdv   = linear | cosOvf;
    wire [2:0] peakIn = max3(peak_r, curVal_r);
    wire [2:0] cellVal = linear ? integData :
                         (mode == RSMT_EXP) ? peakIn : curVal_r;
    wire rangeEnd = doAdv & (rangeAddr_r == 9'(RANGE_LAST));
    wire ulDone   = stepEn & (rangeEnd | (~linear & sinCntWrap));
    wire wrReq    = stepEn & doAdv & (rangeAddr_r[1:0] == 2'b11);

    // Unload sequencer and write-side range path
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            azHold_r     <= 8'h00;
            ulAz_r       <= 8'h00;
            pendAz_r     <= 8'h00;
            ulPend_r     <= 1'b0;
            ulState_r    <= RSMT_UL_IDLE;
            cosCnt_r     <= 10'h000;
            cosReg_r     <= 9'h000;
            sinCnt_r     <= 9'h000;
            sinReg_r     <= 9'h000;
            rangeAddr_r  <= 9'h000;
            curVal_r     <= 3'h0;
            peak_r       <= 3'h0;
            s2p_r        <= 9'h000;
            integShift_r <= 1'b0;
            wrPend_r     <= 1'b0;
            wrData_r     <= 12'h000;
            wrGrp_r      <= 7'h00;
            unloadCnt_r  <= 16'h0000;
        end
        else
        begin
            azHold_r     <= antennaAz;
            integShift_r <= 1'b0;
            // Pending write: a new request wins over completion
            if (wrReq)
                wrPend_r <= 1'b1;
            else if (wrGo)
                wrPend_r <= 1'b0;
            // Azimuth step while busy or writing is remembered for later
            if (azChange & ~ulFree)
                ulPend_r <= 1'b1;
            else if (ulFree)
                ulPend_r <= 1'b0;
            if (azChange & ~ulFree)
                pendAz_r <= azHold_r;
            // Bin to unload is latched only as an unload starts
            if (azChange & ulFree)
                ulAz_r <= azHold_r;
            else if (ulFree & ulPend_r)
                ulAz_r <= pendAz_r;
            case (ulState_r)
                RSMT_UL_IDLE:
                begin
                    if (ulFree & (ulPend_r | azChange))
                        ulState_r <= RSMT_UL_LOAD;
                end
                RSMT_UL_LOAD:
                begin
                    cosCnt_r    <= alt_r;
                    sinCnt_r    <= 9'h000;
                    cosReg_r    <= 9'h000;
                    sinReg_r    <= 9'h000;
                    rangeAddr_r <= 9'h000;
                    peak_r      <= 3'h0;
                    curVal_r    <= integData;
                    unloadCnt_r <= unloadCnt_r + 16'h0001;
                    ulState_r   <= RSMT_UL_RUN;
                end
                RSMT_UL_RUN:
                begin
                    if (stepEn & ~linear)
                    begin
                        cosReg_r <= cosSum[CREG_W-1:0];
                        if (cosOvf)
                            sinCnt_r <= sinCnt_r + 9'h001;
                        if (~dblOvf)
                            sinReg_r <= sinSum[SIN_W-1:0];
                    end
                    if (stepEn & doShift)
                    begin
                        integShift_r <= 1'b1;
                        curVal_r     <= integData;
                    end
                    if (stepEn & doAdv)
                    begin
                        rangeAddr_r <= rangeAddr_r + 9'h001;
                        s2p_r[rangeAddr_r[1:0]*CELL_W +: CELL_W] <= cellVal;
                        peak_r <= doShift ? integData : 3'h0;
                    end
                    else if (stepEn & doShift)
                        peak_r <= peakIn;
                    if (wrReq)
                    begin
                        wrData_r <= {cellVal, s2p_r};
                        wrGrp_r  <= rangeAddr_r[8:2];
                    end
                    if (ulDone)
                        ulState_r <= RSMT_UL_IDLE;
                end
                default:
                    ulState_r <= RSMT_UL_IDLE;
            endcase
        end
    end

    // Top outputs straight from flops
    assign prdata        = prdata_r;
    assign pready        = pready_r;
    assign pslverr       = pslverr_r;
    assign quantClk      = quantClk_r;
    assign integShift    = integShift_r;
    assign compositeSync = compSync_r;
    assign videoWord     = video_r;
    assign bufferLoad    = bufLoad_r;

    // Busy flag registered from the sequencer state and the pending write
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
            unloadBusy <= 1'b0;
        else
            unloadBusy <= (ulState_r != RSMT_UL_IDLE) | wrPend_r;
    end

endmodule
`default_nettype wire

/* File: sim/rsmt_top_sva.sv */
`default_nettype none
module rsmt_top_sva
    import rsmt_pkg::*;
#(
    parameter int VRET_ODD_CYC  = V_ODD_CYC,
    parameter int VRET_EVEN_CYC = V_EVEN_CYC
)(
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic [7:0] antennaAz,
    input wire logic       radarMasterTrigger,
    input wire logic       quantClk,
    input wire logic       integShift,
    input wire logic       compositeSync,
    input wire logic       bufferLoad,
    input wire logic       unloadBusy
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HR = H_TOT_CYC - H_ACT_CYC;
    logic [15:0] run;
    logic [4:0]  ldCnt;
    logic [9:0]  qCnt;
    logic        syncQ;
    logic        seen;
    wire logic   riseS = compositeSync & ~syncQ;
    wire logic   fallS = ~compositeSync & syncQ;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // Sync edge tracking; lengths only trusted after the first full level
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            syncQ <= 1'b0;
            seen  <= 1'b0;
        end
        else
        begin
            syncQ <= compositeSync;
            seen  <= seen | fallS;
        end
    end
    // Level lengths, loads per line and pulses since trigger
    always_ff @(posedge clk_sys)
    begin
        run   <= (riseS | fallS) ? 16'h0001 : run + 16'h0001;
        ldCnt <= riseS ? 5'h00 : ldCnt + {4'h0, bufferLoad};
        qCnt  <= radarMasterTrigger ? 10'h000 : qCnt + {9'h000, quantClk};
    end
    chk_line_act: assert property (riseS && seen |-> run == H_ACT_CYC)
        else $error("active line length wrong");
    chk_retrace_len: assert property (fallS && seen |-> run == HR
            || run == VRET_ODD_CYC + HR || run == VRET_EVEN_CYC + HR
            || run == VRET_ODD_CYC || run == VRET_EVEN_CYC)
        else $error("retrace length wrong");
    chk_line_loads: assert property (riseS && seen |-> ldCnt == 16)
        else $error("buffer loads per line wrong");
    chk_load_pulse: assert property (bufferLoad |=> !bufferLoad)
        else $error("buffer load longer than one cycle");
    chk_quant_max: assert property (quantClk |-> qCnt < QCLK_MAX)
        else $error("quantizer clock beyond its limit");
    chk_trig_start: assert property (radarMasterTrigger |=> !quantClk)
        else $error("quantizer clock too soon after trigger");
    chk_shift_busy: assert property (integShift |-> $past(unloadBusy))
        else $error("integrator shift outside an unload");
    chk_unload_go: assert property ($changed(antennaAz[0])
            |-> ##[1:3] unloadBusy)
        else $error("azimuth step did not start an unload");
endmodule
bind rsmt_top rsmt_top_sva #(
    .VRET_ODD_CYC  (VRET_ODD_CYC),
    .VRET_EVEN_CYC (VRET_EVEN_CYC)
) u_sva (
    .clk_sys(clk_sys), .rst_n(rst_n), .antennaAz(antennaAz),
    .radarMasterTrigger(radarMasterTrigger), .quantClk(quantClk),
    .integShift(integShift), .compositeSync(compositeSync),
    .bufferLoad(bufferLoad), .unloadBusy(unloadBusy)
);
`default_nettype wire

/* File: sim/rsmt_src_model.sv */
`default_nettype none
module rsmt_src_model (
    input  wire logic       clk_sys,
    input  wire logic       trigReq,
    input  wire logic       azStep,
    input  wire logic       integShift,
    output logic            radarMasterTrigger,
    output logic      [7:0] antennaAz,
    output logic      [2:0] integData
);
    timeunit 1ns;
    timeprecision 1ns;
    // Trigger, antenna bin and integrator bin change just after an edge
    always @(posedge clk_sys)
    begin
        radarMasterTrigger <= trigReq;
        antennaAz          <= antennaAz + {7'h00, azStep};
        integData          <= integData + {2'h0, integShift};
    end
    // Antenna at bin zero, integrator on its first bin
    initial
    begin
        radarMasterTrigger = 1'b0;
        antennaAz          = 8'h00;
        integData          = 3'h0;
    end
endmodule
`default_nettype wire

/* File: sim/rsmt_top_tb.sv */
`default_nettype none
module rsmt_top_tb
    import rsmt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'b0, rst_n = 1'b0, trigReq = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, azStep = 1'b0;
    logic [7:0]  paddr = 8'h00, antennaAz;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic [29:0] videoWord;
    logic [2:0]  integData;
    logic        pready, pslverr, quantClk, integShift, compositeSync;
    logic        bufferLoad, unloadBusy, radarMasterTrigger, err;
    int          errors = 0, n_tests = 0, qN = 0, sN = 0, i, base;
    int          nLine = 0;
    logic        syncP;
    always #25 clk_sys = ~clk_sys;
    // Running counts of quantizer clocks, integrator shifts, line starts
    always @(posedge clk_sys)
    begin
        qN <= qN + ((quantClk === 1'b1) ? 1 : 0);
        sN <= sN + ((integShift === 1'b1) ? 1 : 0);
        syncP <= compositeSync;
        nLine <= nLine + ((syncP === 1'b1 && compositeSync === 1'b0)
                          ? 1 : 0);
    end
    rsmt_top #(.VRET_ODD_CYC(40), .VRET_EVEN_CYC(50)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .radarMasterTrigger(radarMasterTrigger), .antennaAz(antennaAz),
        .integData(integData), .quantClk(quantClk),
        .integShift(integShift), .compositeSync(compositeSync),
        .videoWord(videoWord), .bufferLoad(bufferLoad),
        .unloadBusy(unloadBusy));
    rsmt_src_model u_src (.clk_sys(clk_sys), .trigReq(trigReq),
        .azStep(azStep), .integShift(integShift),
        .radarMasterTrigger(radarMasterTrigger), .antennaAz(antennaAz),
        .integData(integData));
    // One APB transfer; holds the request until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 40 && pready !== 1'b1; i++) @(posedge clk_sys);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
        if (i == 40)
            tally_and_finish(1);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Bounded wait on the unload busy level
    task automatic waitBusy(input logic lvl, input int lim);
        for (i = 0; i < lim && unloadBusy !== lvl; i++) @(posedge clk_sys);
        if (i == lim)
            tally_and_finish(1);
    endtask
    task automatic tally_and_finish(input int hung);
        errors += hung;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        // Control reset value, altitude width and an unmapped address
        apb(1'b0, REG_CTRL, 32'h00000000);
        chk("ctrl", {26'h0, CTRL_RST}, rd);
        apb(1'b1, REG_ALT, 32'hFFFFFFFF);
        apb(1'b0, REG_ALT, 32'h00000000);
        chk("alt", 32'h000003FF, rd);
        apb(1'b1, REG_ALT, 32'h00000000);
        apb(1'b0, 8'h10, 32'h00000000);
        chk("unmapped_err", 32'h00000001, {31'h0, err});
        chk("unmapped_data", 32'h00000000, rd);
        $display("test registers done");
        // Trigger refused with write side off, then one full burst
        for (int en = 0; en < 2; en++)
        begin
            apb(1'b1, REG_CTRL, {26'h0, en[0], 5'h00});
            base = qN;
            trigReq <= 1'b1;
            @(posedge clk_sys);
            trigReq <= 1'b0;
            for (i = 0; i < 3000 && qN - base < 512 * en; i++)
                @(posedge clk_sys);
            repeat (100) @(posedge clk_sys);
            chk("quant_pulses", 512 * en, qN - base);
            apb(1'b0, REG_COUNT, 32'h00000000);
            chk("quant_count", 512 * en, {22'h0, rd[9:0]});
        end
        $display("test trigger done");
        // One unload per mode at zero altitude: one shift per cell
        for (int m = 0; m < 3; m++)
        begin
            apb(1'b1, REG_CTRL, {26'h0, 4'h8, m[1:0]});
            base = sN;
            azStep <= 1'b1;
            @(posedge clk_sys);
            azStep <= 1'b0;
            waitBusy(1'b1, 8);
            waitBusy(1'b0, 20000);
            chk("shifts", 32'd512, sN - base);
        end
        apb(1'b0, REG_COUNT, 32'h00000000);
        chk("unloads", 32'd3, {16'h0, rd[31:16]});
        $display("test unload done");
        // Bins 0 and 1 read back at line start: cell 2n holds 2n mod 8
        for (i = 0; i < 3000 && !(bufferLoad === 1'b1 && syncP === 1'b1);
             i++)
            @(posedge clk_sys);
        if (i == 3000)
            tally_and_finish(1);
        base = ((nLine + 1) * 2) % 8;
        chk("video_bin0", base, {29'h0, videoWord[2:0]});
        repeat (READ_SLOT) @(posedge clk_sys);
        chk("load_slot1", 32'd1, {31'h0, bufferLoad});
        chk("video_bin1", base, {29'h0, videoWord[2:0]});
        chk("sync_low", 32'd0, {31'h0, compositeSync});
        $display("test readback done");
        tally_and_finish(0);
    end
endmodule
`default_nettype wire
